// *** core/tcp_port_ctrl.sv ***
// Dual Type-C source port controller with AXI4-Lite status and control
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module tcp_port_ctrl
  import tcp_pkg::*;
#(
  parameter int unsigned P_SCP_OFF_CYC = SCP_OFF_CYC,
  parameter int unsigned P_OVERLOAD_CYC = OVERLOAD_CYC,
  parameter int unsigned P_HICCUP_OFF_CYC = HICCUP_OFF_CYC
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic input_undervoltage_lockout,
  input wire logic over_temp,
  input wire tcp_port_in_t [1:0] port_in,
  output tcp_port_out_t [1:0] port_out,
  output logic buck_en,
  output logic [7:0] ldc_mv,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam logic [CNT_W-1:0] SCP_LAST = CNT_W'(P_SCP_OFF_CYC - 1);
  localparam logic [CNT_W-1:0] OVL_LAST = CNT_W'(P_OVERLOAD_CYC - 1);
  localparam logic [CNT_W-1:0] HIC_LAST = CNT_W'(P_HICCUP_OFF_CYC - 1);
  localparam logic [LOW_W-1:0] LOW_LAST = LOW_W'(LOW_QUAL_CYC - 1);
  localparam logic [PROBE_W-1:0] PROBE_LAST = PROBE_W'(PROBE_CYC - 1);
  localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEBOUNCE_CYC - 1);

  // Termination vector {a_rd, a_ra, b_rd, b_ra}: exactly one Rd is a sink;
  // Rd/Rd (debug) and Ra/Ra (audio) never qualify
  function automatic logic term_sink(input logic [3:0] t);
    term_sink = t[3] ^ t[1];
  endfunction

  // Connector supply goes to the pin showing Ra opposite the Rd pin
  function automatic logic [1:0] term_vconn(input logic [3:0] t);
    term_vconn = {t[2] & t[1] & ~t[3], t[0] & t[3] & ~t[1]};
  endfunction

  function automatic logic [7:0] ldc_calc(input logic [7:0] code);
    logic [15:0] prod;
    logic [15:0] quo;
    prod = 16'(code) * 16'(LDC_MV_AT_REF);
    quo = prod / LDC_REF_CODE;
    ldc_calc = (quo > 16'(LDC_MAX_MV)) ? LDC_MAX_MV : quo[7:0];
  endfunction

  // Synchronisers
  tcp_cmp_t [1:0] cmp_m_ff;
  tcp_cmp_t [1:0] cmp_s_ff;
  logic [1:0] glob_m_ff;
  logic [1:0] glob_s_ff;
  logic [7:0] isense_ff [2];

  // Per-port state
  logic [3:0] term_ff [2];
  logic [3:0] deb_last_ff [2];
  logic [DEB_W-1:0] deb_cnt_ff [2];
  tcp_pstate_t state_ff [2];
  tcp_fault_t fault_ff [2];
  logic [PROBE_W-1:0] probe_cnt_ff [2];
  logic [CNT_W-1:0] fcnt_ff [2];
  logic [CNT_W-1:0] ovl_ff [2];
  logic [LOW_W-1:0] low_ff [2];
  logic [1:0] pwr_prev_ff;
  logic [1:0] dis_ff;
  tcp_port_out_t [1:0] out_ff;
  logic buck_ff;
  logic [7:0] ldc_ff;
  logic [1:0] ctrl_ff;

  logic [3:0] nxt_term [2];
  logic [3:0] nxt_deb_last [2];
  logic [DEB_W-1:0] nxt_deb_cnt [2];
  tcp_pstate_t nxt_state [2];
  tcp_fault_t nxt_fault [2];
  logic [PROBE_W-1:0] nxt_probe_cnt [2];
  logic [CNT_W-1:0] nxt_fcnt [2];
  logic [CNT_W-1:0] nxt_ovl [2];
  logic [LOW_W-1:0] nxt_low [2];
  logic [1:0] nxt_dis;
  tcp_port_out_t [1:0] nxt_out;
  logic [1:0] pwr_ok;

  wire shdn = glob_s_ff[0] | glob_s_ff[1];
  wire [7:0] isense_max = (isense_ff[0] > isense_ff[1]) ? isense_ff[0] : isense_ff[1];
  wire [7:0] nxt_ldc = ldc_calc(isense_max);
  wire nxt_buck = ~shdn & |pwr_ok;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cmp_m_ff <= '0;
      cmp_s_ff <= '0;
      glob_m_ff <= 2'h0;
      glob_s_ff <= 2'h0;
    end else begin
      cmp_m_ff <= {port_in[1].cmp, port_in[0].cmp};
      cmp_s_ff <= cmp_m_ff;
      glob_m_ff <= {over_temp, input_undervoltage_lockout};
      glob_s_ff <= glob_m_ff;
    end
  end

  // Power allowed: attached or legacy, not shut down, not parked by software
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      pwr_ok[p] = ((state_ff[p] == PS_ATTACH) || (state_ff[p] == PS_LEGACY)) && !shdn
        && !ctrl_ff[p];
    end
  end

  // Per-port next state; both ports run the same code on their own state
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      logic [3:0] raw;
      logic fast_short_turnoff;
      logic ccl;
      logic low;
      logic ovl_hit;
      logic low_hit;
      logic [1:0] vsel;
      raw = {cmp_s_ff[p].cc_a_rd, cmp_s_ff[p].cc_a_ra, cmp_s_ff[p].cc_b_rd, cmp_s_ff[p].cc_b_ra};
      fast_short_turnoff = cmp_s_ff[p].ilim_secondary;
      ccl = cmp_s_ff[p].ilim_cc;
      low = cmp_s_ff[p].ss_done & cmp_s_ff[p].out_low;
      ovl_hit = ccl && (ovl_ff[p] == OVL_LAST);
      low_hit = low && (low_ff[p] == LOW_LAST);
      vsel = term_vconn(term_ff[p]);

      // Debounce: terminations must stay put for the whole window
      nxt_deb_last[p] = raw;
      nxt_term[p] = term_ff[p];
      nxt_deb_cnt[p] = deb_cnt_ff[p];
      if (raw != deb_last_ff[p]) begin
        nxt_deb_cnt[p] = '0;
      end else if (deb_cnt_ff[p] == DEB_LAST) begin
        nxt_term[p] = raw;
      end else begin
        nxt_deb_cnt[p] = deb_cnt_ff[p] + 1'b1;
      end

      nxt_state[p] = state_ff[p];
      nxt_probe_cnt[p] = probe_cnt_ff[p];
      unique case (state_ff[p])
        PS_PROBE: begin
          if (probe_cnt_ff[p] == PROBE_LAST) begin
            nxt_state[p] = cmp_s_ff[p].cc_a_legacy ? PS_LEGACY : PS_OPEN;
          end else begin
            nxt_probe_cnt[p] = probe_cnt_ff[p] + 1'b1;
          end
        end
        PS_OPEN: begin
          if (term_sink(term_ff[p]) && !shdn && !ctrl_ff[p]) begin
            nxt_state[p] = PS_ATTACH;
          end
        end
        PS_ATTACH: begin
          if (!term_sink(term_ff[p]) || shdn || ctrl_ff[p]) begin
            nxt_state[p] = PS_OPEN;
          end
        end
        PS_LEGACY: nxt_state[p] = PS_LEGACY;
      endcase

      // Fault sequencing
      nxt_fault[p] = fault_ff[p];
      nxt_fcnt[p] = fcnt_ff[p];
      nxt_ovl[p] = ovl_ff[p];
      nxt_low[p] = low_ff[p];
      if (!pwr_ok[p]) begin
        nxt_fault[p] = F_RUN;
        nxt_fcnt[p] = '0;
        nxt_ovl[p] = '0;
        nxt_low[p] = '0;
      end else begin
        unique case (fault_ff[p])
          F_RUN, F_SCP_REG: begin
            nxt_ovl[p] = ccl ? ovl_ff[p] + 1'b1 : '0;
            nxt_low[p] = low ? low_ff[p] + 1'b1 : '0;
            if ((fault_ff[p] == F_RUN) && fast_short_turnoff) begin
              nxt_fault[p] = F_SCP_OFF;
              nxt_fcnt[p] = '0;
            end else if (ovl_hit || low_hit) begin
              nxt_fault[p] = F_HIC_OFF;
              nxt_fcnt[p] = '0;
              nxt_ovl[p] = '0;
              nxt_low[p] = '0;
            end else if ((fault_ff[p] == F_SCP_REG) && cmp_s_ff[p].ss_done && !ccl && !fast_short_turnoff) begin
              nxt_fault[p] = F_RUN;
            end
          end
          F_SCP_OFF: begin
            if (fcnt_ff[p] == SCP_LAST) begin
              nxt_fault[p] = F_SCP_REG;
              nxt_fcnt[p] = '0;
            end else begin
              nxt_fcnt[p] = fcnt_ff[p] + 1'b1;
            end
          end
          F_HIC_OFF: begin
            if (fcnt_ff[p] == HIC_LAST) begin
              nxt_fault[p] = F_RUN;
              nxt_fcnt[p] = '0;
            end else begin
              nxt_fcnt[p] = fcnt_ff[p] + 1'b1;
            end
          end
        endcase
      end

      // Set wins over the clear so a release in the same cycle is kept
      nxt_dis[p] = shdn || (pwr_prev_ff[p] && !pwr_ok[p])
        || (dis_ff[p] && !cmp_s_ff[p].out_discharged);

      nxt_out[p].pwr_sw_on = pwr_ok[p] && ((nxt_fault[p] == F_RUN)
        || (nxt_fault[p] == F_SCP_REG));
      nxt_out[p].fast_off = pwr_ok[p] && (fault_ff[p] == F_RUN) && fast_short_turnoff;
      nxt_out[p].reg_ilim = pwr_ok[p] && (nxt_fault[p] == F_SCP_REG);
      nxt_out[p].legacy_ilim = (state_ff[p] == PS_LEGACY);
      nxt_out[p].vconn_a = pwr_ok[p] && (state_ff[p] == PS_ATTACH) && vsel[1];
      nxt_out[p].vconn_b = pwr_ok[p] && (state_ff[p] == PS_ATTACH) && vsel[0];
      nxt_out[p].pullup_a = (state_ff[p] == PS_OPEN) || (state_ff[p] == PS_ATTACH);
      nxt_out[p].pullup_b = (state_ff[p] == PS_OPEN) || (state_ff[p] == PS_ATTACH);
      nxt_out[p].rp_level = RP_LEVEL_3A;
      nxt_out[p].probe_src = (state_ff[p] == PS_PROBE);
      nxt_out[p].discharge = nxt_dis[p];
      // Fresh soft start on power-up and after each forced off period
      nxt_out[p].ss_restart = pwr_ok[p] && (!pwr_prev_ff[p]
        || ((fault_ff[p] != F_RUN) && (fault_ff[p] != F_SCP_REG)
        && (nxt_fault[p] != fault_ff[p])));
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int p = 0; p < 2; p++) begin
        term_ff[p] <= 4'h0;
        deb_last_ff[p] <= 4'h0;
        deb_cnt_ff[p] <= '0;
        state_ff[p] <= PS_PROBE;
        fault_ff[p] <= F_RUN;
        probe_cnt_ff[p] <= '0;
        fcnt_ff[p] <= '0;
        ovl_ff[p] <= '0;
        low_ff[p] <= '0;
        isense_ff[p] <= 8'h00;
      end
      pwr_prev_ff <= 2'h0;
      dis_ff <= {2{DIS_RST}};
      out_ff <= {2{tcp_port_out_t'{discharge: DIS_RST, default: '0}}};
      buck_ff <= 1'b0;
      ldc_ff <= 8'h00;
    end else begin
      for (int p = 0; p < 2; p++) begin
        term_ff[p] <= nxt_term[p];
        deb_last_ff[p] <= nxt_deb_last[p];
        deb_cnt_ff[p] <= nxt_deb_cnt[p];
        state_ff[p] <= nxt_state[p];
        fault_ff[p] <= nxt_fault[p];
        probe_cnt_ff[p] <= nxt_probe_cnt[p];
        fcnt_ff[p] <= nxt_fcnt[p];
        ovl_ff[p] <= nxt_ovl[p];
        low_ff[p] <= nxt_low[p];
        isense_ff[p] <= port_in[p].isense;
      end
      pwr_prev_ff <= pwr_ok;
      dis_ff <= nxt_dis;
      out_ff <= nxt_out;
      buck_ff <= nxt_buck;
      ldc_ff <= nxt_ldc;
    end
  end

  assign port_out = out_ff;
  assign buck_en = buck_ff;
  assign ldc_mv = ldc_ff;

  // AXI4-Lite slave: one write and one read at a time
  logic aw_have_ff;
  logic w_have_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    for (int p = 0; p < 2; p++) begin
      status_word[p*ST_PORT_STRIDE+ST_STATE_LSB +: 2] = state_ff[p];
      status_word[p*ST_PORT_STRIDE+ST_FAULT_LSB +: 2] = fault_ff[p];
      status_word[p*ST_PORT_STRIDE+ST_VCONN_BIT] = out_ff[p].vconn_a | out_ff[p].vconn_b;
      status_word[p*ST_PORT_STRIDE+ST_DIS_BIT] = dis_ff[p];
      status_word[p*ST_PORT_STRIDE+ST_PWR_BIT] = out_ff[p].pwr_sw_on;
    end
    status_word[ST_SHDN_BIT] = shdn;
    status_word[ST_BUCK_BIT] = buck_ff;
  end

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_have_ff && w_have_ff && !bvalid_ff;
  wire wr_ctrl = wr_go && (awaddr_ff == REG_CTRL) && wstrb_ff[0];
  wire wr_known = (awaddr_ff == REG_CTRL) || (awaddr_ff == REG_STATUS) || (awaddr_ff == REG_LDC);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rd_ctrl = (s_axi_araddr == REG_CTRL);
  wire rd_stat = (s_axi_araddr == REG_STATUS);
  wire rd_ldc = (s_axi_araddr == REG_LDC);
  wire [31:0] rd_mux = rd_ctrl ? {30'h0, ctrl_ff} : rd_stat ? status_word
    : rd_ldc ? {24'h0, ldc_ff} : 32'h0000_0000;

  assign s_axi_awready = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready = !w_have_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      ctrl_ff <= CTRL_RST;
    end else begin
      if (aw_take) begin
        aw_have_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_ff <= wdata_ff[CTRL_OFF_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= (rd_ctrl || rd_stat || rd_ldc) ? RESP_OKAY : RESP_SLVERR;
      rdata_ff <= rd_mux;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule

// *** inc/tcp_pkg.sv ***
// Shared constants, types and register map of the dual Type-C port controller
package tcp_pkg;
  // Clock and timing, each time in its own unit and a derived cycle count
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned T_SCP_OFF_US = 100;
  localparam int unsigned SCP_OFF_CYC = T_SCP_OFF_US * CLK_PER_US;
  localparam int unsigned T_OVERLOAD_MS = 5;
  localparam int unsigned OVERLOAD_CYC = T_OVERLOAD_MS * 1000 * CLK_PER_US;
  localparam int unsigned T_HICCUP_OFF_S = 2;
  localparam int unsigned HICCUP_OFF_CYC = T_HICCUP_OFF_S * CLK_HZ;
  localparam int unsigned T_LOW_QUAL_US = 50;
  localparam int unsigned LOW_QUAL_CYC = T_LOW_QUAL_US * CLK_PER_US;
  localparam int unsigned T_PROBE_US = 20;
  localparam int unsigned PROBE_CYC = T_PROBE_US * CLK_PER_US;
  localparam int unsigned T_DEBOUNCE_US = 10;
  localparam int unsigned DEBOUNCE_CYC = T_DEBOUNCE_US * CLK_PER_US;

  // Counter widths
  localparam int CNT_W = 27;
  localparam int LOW_W = 12;
  localparam int PROBE_W = 10;
  localparam int DEB_W = 10;

  // Line-drop compensation: current code LSB is 25 mA, so 3 A is code 120
  localparam logic [7:0] LDC_MV_AT_REF = 8'h5A;
  localparam logic [15:0] LDC_REF_CODE = 16'h0078;
  localparam logic [7:0] LDC_MAX_MV = 8'h78;

  // Pull-up advertisement level code for 3 A
  localparam logic [1:0] RP_LEVEL_3A = 2'h3;

  // Register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_LDC = 8'h08;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int CTRL_OFF_LSB = 0;
  localparam int ST_PORT_STRIDE = 8;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_FAULT_LSB = 2;
  localparam int ST_VCONN_BIT = 5;
  localparam int ST_DIS_BIT = 6;
  localparam int ST_PWR_BIT = 7;
  localparam int ST_SHDN_BIT = 16;
  localparam int ST_BUCK_BIT = 17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic DIS_RST = 1'b1;

  typedef enum logic [1:0] {
    PS_PROBE = 2'b00,
    PS_OPEN = 2'b01,
    PS_ATTACH = 2'b10,
    PS_LEGACY = 2'b11
  } tcp_pstate_t;

  typedef enum logic [1:0] {
    F_RUN = 2'b00,
    F_SCP_OFF = 2'b01,
    F_SCP_REG = 2'b10,
    F_HIC_OFF = 2'b11
  } tcp_fault_t;

  // Analog comparator results of one port
  typedef struct packed {
    logic cc_a_rd;
    logic cc_a_ra;
    logic cc_b_rd;
    logic cc_b_ra;
    logic cc_a_legacy;
    logic ilim_secondary;
    logic ilim_cc;
    logic out_low;
    logic out_discharged;
    logic ss_done;
  } tcp_cmp_t;

  typedef struct packed {
    tcp_cmp_t cmp;
    logic [7:0] isense;
  } tcp_port_in_t;

  typedef struct packed {
    logic pwr_sw_on;
    logic fast_off;
    logic reg_ilim;
    logic legacy_ilim;
    logic vconn_a;
    logic vconn_b;
    logic pullup_a;
    logic pullup_b;
    logic [1:0] rp_level;
    logic probe_src;
    logic discharge;
    logic ss_restart;
  } tcp_port_out_t;
endpackage

// *** testbench/tcp_port_ctrl_monitor.sv ***
// Concurrent checks on the outputs of the dual port controller
`timescale 1ns/1ns
module tcp_port_ctrl_monitor
  import tcp_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic input_undervoltage_lockout,
  input wire logic over_temp,
  input wire tcp_port_in_t [1:0] port_in,
  input wire tcp_port_out_t [1:0] port_out,
  input wire logic buck_en,
  input wire logic [7:0] ldc_mv
);
  tcp_port_in_t i0;
  tcp_port_in_t i1;
  tcp_port_out_t o0;
  tcp_port_out_t o1;
  logic [7:0] big;
  logic [15:0] ldc_raw;
  logic [7:0] ldc_exp;
  wire shdn = input_undervoltage_lockout || over_temp;
  wire acc1 = (i1.cmp.cc_a_rd && i1.cmp.cc_b_rd) || (i1.cmp.cc_a_ra && i1.cmp.cc_b_ra);
  assign i0 = port_in[0];
  assign i1 = port_in[1];
  assign o0 = port_out[0];
  assign o1 = port_out[1];
  assign big = (i0.isense > i1.isense) ? i0.isense : i1.isense;
  assign ldc_raw = ({8'h00, big} * 16'h005A) / 16'h0078;
  // Above the cap the figure is clipped, not wrapped
  assign ldc_exp = (ldc_raw > 16'h0078) ? 8'h78 : ldc_raw[7:0];
  // Supply may outlive its cable load by the debounce window
  localparam logic [9:0] NO_LOAD_LAST = 10'(DEBOUNCE_CYC + 16);
  logic [9:0] no_load_ff;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) no_load_ff <= 10'h000;
    else if (i1.cmp.cc_b_ra) no_load_ff <= 10'h000;
    else if (no_load_ff != NO_LOAD_LAST) no_load_ff <= no_load_ff + 10'h001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  fast_turn_off_a: assert property ($rose(i0.cmp.ilim_secondary)
    && o0.pwr_sw_on && !o0.reg_ilim |-> ##[1:4] !o0.pwr_sw_on) else $error("switch not cut");
  off_hold_a: assert property ($rose(o0.fast_off) |-> (!o0.pwr_sw_on) [*8])
    else $error("switch back too soon");
  line_drop_a: assert property (($stable(i0.isense) && $stable(i1.isense)) [*4]
    |-> ldc_mv == ldc_exp) else $error("compensation wrong");
  rp_level_a: assert property (!$past(reset)
    |-> o0.rp_level == RP_LEVEL_3A && o1.rp_level == RP_LEVEL_3A) else $error("pull-up level");
  vconn_pin_a: assert property (no_load_ff == NO_LOAD_LAST |-> !o1.vconn_b)
    else $error("supply without cable load");
  shutdown_off_a: assert property (shdn [*6] |-> !buck_en && !o0.pwr_sw_on
    && !o1.pwr_sw_on && !o0.vconn_a && !o1.vconn_b) else $error("output on in shutdown");
  discharge_on_a: assert property ($rose(shdn) |-> ##[1:6] o0.discharge)
    else $error("no discharge");
  discharge_off_a: assert property ((i0.cmp.out_discharged && !shdn && !o0.pwr_sw_on) [*8]
    |-> !o0.discharge) else $error("discharge left on");
  accessory_off_a: assert property (acc1 [*8] |-> !o1.pwr_sw_on)
    else $error("accessory powered");
  buck_on_a: assert property ((o0.pwr_sw_on && !shdn) [*3] |-> buck_en)
    else $error("buck off while port on");
endmodule

bind tcp_port_ctrl tcp_port_ctrl_monitor tcp_port_ctrl_monitor_inst (.clock, .reset, .input_undervoltage_lockout,
  .over_temp, .port_in, .port_out, .buck_en, .ldc_mv);

// *** testbench/tcp_sink_model.sv ***
// Attached sink, cable or accessory on one port, with a crude output rail
`timescale 1ns/1ns
module tcp_sink_model
  import tcp_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [2:0] mode,
  input wire logic [2:0] fault,
  input wire logic [7:0] isense,
  input wire tcp_port_out_t pout,
  output tcp_port_in_t pin
);
  // Modes: 0 open, 1 Rd on a and Ra on b, 2 audio, 3 debug, 4 legacy resistor, 5 Rd on b
  logic [3:0] v_ff;
  logic [3:0] nxt_v;
  wire rd_a = mode == 3'h1 || mode == 3'h3;
  wire rd_b = mode == 3'h3 || mode == 3'h5;
  wire ra_b = mode == 3'h1 || mode == 3'h2;
  wire ra_a = mode == 3'h2;
  // Terminations read back only while the pin is pulled up or powered, the legacy resistor only while the probe source is on
  assign pin.cmp.cc_a_rd = pout.pullup_a && rd_a;
  assign pin.cmp.cc_a_ra = (pout.pullup_a || pout.vconn_a) && ra_a;
  assign pin.cmp.cc_b_rd = pout.pullup_b && rd_b;
  assign pin.cmp.cc_b_ra = (pout.pullup_b || pout.vconn_b) && ra_b;
  assign pin.cmp.cc_a_legacy = pout.probe_src && mode == 3'h4;
  assign pin.cmp.ilim_secondary = fault[0];
  assign pin.cmp.ilim_cc = fault[1];
  assign pin.cmp.out_low = fault[2];
  assign pin.cmp.out_discharged = v_ff == 4'h0;
  assign pin.cmp.ss_done = v_ff == 4'hF;
  assign pin.isense = isense;
  // The rail falls only through the discharge path or to zero on a soft-start restart, so a stuck path shows up at once
  assign nxt_v = pout.ss_restart ? 4'h0
    : (pout.pwr_sw_on && v_ff != 4'hF) ? v_ff + 4'h1
    : (pout.discharge && !pout.pwr_sw_on && v_ff != 4'h0) ? v_ff - 4'h1 : v_ff;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) v_ff <= 4'h0;
    else v_ff <= nxt_v;
  end
endmodule

// *** testbench/tb.sv ***
// Directed tests of the dual port controller through its pins and register bus
`timescale 1ns/1ns
module tb
  import tcp_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic input_undervoltage_lockout = 1'b0;
  logic over_temp = 1'b0;
  logic [2:0] mode0 = 3'h0, mode1 = 3'h0, flt0 = 3'h0, flt1 = 3'h0;
  logic [7:0] is0 = 8'h00, is1 = 8'h00, awaddr = 8'h00, araddr = 8'h00, ldc_mv;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, buck_en;
  logic [1:0] bresp, rresp, rsp;
  tcp_port_in_t [1:0] port_in;
  tcp_port_out_t [1:0] port_out;
  int error_cnt = 0;
  int n_compared = 0;
  int n;
  always #10 clock = ~clock;
  tcp_port_ctrl #(.P_SCP_OFF_CYC(20), .P_OVERLOAD_CYC(50), .P_HICCUP_OFF_CYC(100))
  tcp_port_ctrl_inst (.clock(clock), .reset(reset), .input_undervoltage_lockout(input_undervoltage_lockout), .over_temp(over_temp),
    .port_in(port_in), .port_out(port_out), .buck_en(buck_en), .ldc_mv(ldc_mv),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  tcp_sink_model sink0_inst (.clock(clock), .reset(reset), .mode(mode0), .fault(flt0),
    .isense(is0), .pout(port_out[0]), .pin(port_in[0]));
  tcp_sink_model sink1_inst (.clock(clock), .reset(reset), .mode(mode1), .fault(flt1),
    .isense(is1), .pout(port_out[1]), .pin(port_in[1]));
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_flag(input logic g, input logic e, input string m);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h", $time, m, g);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clock);
  endtask
  // Ready is looked at mid-cycle, where it is settled, and acted on at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ha, hw, hb;
    int k;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hb = 1'b0;
    for (k = 0; k < 50 && !hb; k++) begin
      @(negedge clock);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      rsp = bresp;
      @(posedge clock);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end
    chk_flag(hb, 1'b1, "write answer");
  endtask
  task automatic rdw(input logic [7:0] a);
    logic ha, hr;
    int k;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hr = 1'b0;
    for (k = 0; k < 50 && !hr; k++) begin
      @(negedge clock);
      ha = arvalid && arready;
      hr = rvalid && rready;
      rd = rdata;
      rsp = rresp;
      @(posedge clock);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end
    chk_flag(hr, 1'b1, "read answer");
  endtask
  task automatic start(input logic [2:0] m0, input logic [2:0] m1);
    reset <= 1'b1;
    mode0 <= m0;
    mode1 <= m1;
    cyc(12);
    chk_flag(port_out[0].discharge, 1'b1, "discharge in reset");
    chk_flag(buck_en || port_out[1].pwr_sw_on, 1'b0, "on in reset");
    reset <= 1'b0;
    cyc(1100);
  endtask
  initial begin
    #1_000_000;
    error_cnt++;
    $display("unexpected at %0t: watchdog", $time);
    end_of_test;
  end
  initial begin
    start(3'h0, 3'h0);
    chk_flag(buck_en || port_out[0].pwr_sw_on, 1'b0, "idle output");
    chk_flag(port_out[1].pullup_a && port_out[1].pullup_b, 1'b1, "pull-ups");
    rdw(REG_STATUS);
    chk_word(rd & 32'h0003_0303, 32'h0000_0101, "status idle");
    rdw(8'h0C);
    chk_word({rd[29:0], rsp}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(8'h0C, 32'h1, 4'hF);
    chk_word({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write");
    for (int m = 2; m < 4; m++) begin
      mode1 <= m[2:0];
      cyc(700);
      chk_flag(port_out[1].pwr_sw_on || buck_en, 1'b0, "accessory");
    end
    mode1 <= 3'h1;
    cyc(400);
    chk_flag(port_out[1].pwr_sw_on, 1'b0, "attach before debounce");
    cyc(300);
    chk_flag(port_out[1].pwr_sw_on && buck_en, 1'b1, "attach");
    chk_word({port_out[1].vconn_a, port_out[1].vconn_b}, 32'h1, "supply pin");
    mode1 <= 3'h0;
    for (n = 0; n < 700 && port_out[1].discharge !== 1'b1; n++) @(posedge clock);
    chk_flag(port_out[1].discharge, 1'b1, "release discharge");
    chk_flag(port_out[1].pwr_sw_on || port_out[1].vconn_b, 1'b0, "detach");
    cyc(60);
    chk_flag(port_out[1].discharge, 1'b0, "discharge done");
    mode1 <= 3'h5;
    cyc(700);
    chk_word({port_out[1].pwr_sw_on, port_out[1].vconn_a, port_out[1].vconn_b}, 32'h4,
      "no cable load");
    is0 <= 8'h78;
    is1 <= 8'h28;
    cyc(10);
    chk_word({24'h0, ldc_mv}, 32'h5A, "line drop");
    is1 <= 8'hC8;
    cyc(10);
    rdw(REG_LDC);
    chk_word(rd & 32'hFF, 32'h78, "line drop cap");
    input_undervoltage_lockout <= 1'b1;
    cyc(10);
    chk_word({buck_en, port_out[1].pwr_sw_on, port_out[1].discharge}, 32'h1, "input_undervoltage_lockout");
    input_undervoltage_lockout <= 1'b0;
    over_temp <= 1'b1;
    cyc(60);
    chk_flag(buck_en || port_out[1].pwr_sw_on, 1'b0, "hot");
    over_temp <= 1'b0;
    cyc(700);
    chk_flag(buck_en && port_out[1].pwr_sw_on, 1'b1, "cooled");
    $display("test type-c attach done");
    start(3'h4, 3'h0);
    chk_flag(port_out[0].pwr_sw_on && port_out[0].legacy_ilim && buck_en, 1'b1, "legacy");
    mode0 <= 3'h0;
    mode1 <= 3'h4;
    cyc(700);
    chk_flag(port_out[0].pwr_sw_on, 1'b1, "legacy detach");
    chk_flag(port_out[1].pwr_sw_on, 1'b0, "late legacy");
    wr(REG_CTRL, 32'h1, 4'h1);
    wr(REG_CTRL, 32'h0, 4'h0);
    rdw(REG_CTRL);
    chk_word(rd & 32'h3, 32'h1, "park readback");
    chk_flag(port_out[0].pwr_sw_on, 1'b0, "parked");
    $display("test legacy port one done");
    start(3'h1, 3'h4);
    cyc(600);
    chk_word({port_out[1].legacy_ilim, port_out[0].legacy_ilim}, 32'h2, "legacy two");
    chk_flag(port_out[0].pwr_sw_on && port_out[1].pwr_sw_on, 1'b1, "both on");
    flt0 <= 3'h1;
    for (n = 0; n < 10 && port_out[0].fast_off !== 1'b1; n++) @(posedge clock);
    chk_flag(n < 5 && !port_out[0].pwr_sw_on, 1'b1, "fast turn-off");
    cyc(15);
    chk_flag(port_out[0].pwr_sw_on, 1'b0, "off interval");
    cyc(10);
    chk_flag(port_out[0].pwr_sw_on && port_out[0].reg_ilim, 1'b1, "regulated");
    cyc(20);
    chk_flag(port_out[0].pwr_sw_on, 1'b1, "short held");
    flt0 <= 3'h0;
    cyc(40);
    chk_flag(port_out[0].reg_ilim, 1'b0, "back to run");
    flt0 <= 3'h2;
    cyc(30);
    chk_flag(port_out[0].pwr_sw_on, 1'b1, "overload early");
    cyc(40);
    chk_word({port_out[0].pwr_sw_on, port_out[1].pwr_sw_on}, 32'h1, "hiccup");
    cyc(50);
    chk_flag(port_out[0].pwr_sw_on, 1'b0, "hiccup off");
    cyc(60);
    chk_flag(port_out[0].pwr_sw_on, 1'b1, "hiccup on");
    flt0 <= 3'h0;
    cyc(300);
    flt0 <= 3'h4;
    cyc(2400);
    chk_flag(port_out[0].pwr_sw_on, 1'b1, "low early");
    cyc(150);
    chk_flag(port_out[0].pwr_sw_on, 1'b0, "low output");
    flt0 <= 3'h0;
    $display("test faults done");
    end_of_test;
  end
endmodule
